// [hw/clhi_params.svh]
/*
 * constants of the character display host port: timing counts, memory
 * sizes, command bit positions and field positions.
 * assumes it is included by the package, the design files and the checker.
 */
`ifndef CLHI_PARAMS_SVH
`define CLHI_PARAMS_SVH

// ==========================================================
// timing
`define CLHI_CLK_NS       40
`define CLHI_T_OP_NS      18500
`define CLHI_T_CLR_NS     760000
// least execution times round up to whole clock cycles
`define CLHI_OP_CYC  ((`CLHI_T_OP_NS + `CLHI_CLK_NS - 1) / `CLHI_CLK_NS)
`define CLHI_CLR_CYC ((`CLHI_T_CLR_NS + `CLHI_CLK_NS - 1) / `CLHI_CLK_NS)
`define CLHI_SCAN_DIV     8'h19

// ==========================================================
// memories and panel
`define CLHI_TEXT_DEPTH   80
`define CLHI_LINE_LEN     40
`define CLHI_TEXT_LAST    7'h4F
`define CLHI_LINE1_LAST   7'h27
`define CLHI_LINE2_BASE   7'h40
`define CLHI_LINE2_LAST   7'h67
`define CLHI_GLYPH_DEPTH  64
`define CLHI_SEG_W        40
`define CLHI_COM_W        16
`define CLHI_BLANK        8'h20

// ==========================================================
// command decode: position of the leading one
`define CLHI_CMD_CLR      0
`define CLHI_CMD_HOME     1
`define CLHI_CMD_ENTRY    2
`define CLHI_CMD_DISP     3
`define CLHI_CMD_SHIFT    4
`define CLHI_CMD_FUNC     5
`define CLHI_CMD_GLYPHA   6
`define CLHI_CMD_TEXTA    7
// fields
`define CLHI_F_ID         1
`define CLHI_F_SH         0
`define CLHI_F_D          2
`define CLHI_F_C          1
`define CLHI_F_B          0
`define CLHI_F_SC         3
`define CLHI_F_RL         2
`define CLHI_F_DL         4
`define CLHI_F_N          3
`define CLHI_F_FONT       2

`endif

// [hw/clhi_pkg.sv]
/*
 * types of the character display host port: states and register sets.
 * assumes clhi_params.svh sits on the include path.
 */
`include "clhi_params.svh"

package clhi_pkg;

    // ======================================================
    // main control states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,   // ready for the host
        ST_EXEC = 3'h2,   // instruction or transfer running
        ST_CLR  = 3'h4    // clear fill running
    } clhi_state_type;

    // main block state
    typedef struct packed {
        clhi_state_type               st;
        logic [15:0]                  cnt;     // execution countdown
        logic [6:0]                   ptr;     // address_pointer
        logic                         sel_cg;  // pointer aims at glyphs
        logic [7:0]                   cmd;     // command_register
        logic [7:0]                   dr;      // data_holding_register
        logic                         id;
        logic                         sh_en;
        logic                         disp;
        logic                         cur;
        logic                         blk;
        logic                         dl;      // bus_width_bit
        logic                         nl;      // line-count bit
        logic                         font;
        logic [6:0]                   shift;
        logic                         nib;     // second nibble due
        logic [3:0]                   hi_nib;
        logic                         en_d;
        logic [6:0]                   clr_idx;
        logic                         reload;
        logic [7:0]                   dout;
        logic                         oe;
        logic [`CLHI_TEXT_DEPTH-1:0][7:0]  text;
        logic [`CLHI_GLYPH_DEPTH-1:0][7:0] glyph;
        logic [2:0]                   dot;
        logic [2:0]                   chr;
        logic [3:0]                   row;
        logic [5:0]                   frame;
        logic [`CLHI_COM_W-1:0]       com;
    } clhi_main_type;

    typedef struct packed {
        logic [7:0] div;
        logic       tick;
    } clhi_tick_type;

    typedef struct packed {
        logic [`CLHI_SEG_W-1:0] chain;
        logic [`CLHI_SEG_W-1:0] hold;
    } clhi_seg_type;

endpackage : clhi_pkg

// [hw/clhi_tick.sv]
/*
 * internal timing generator: one-cycle scan enable from the system clock.
 * assumes a single free running clock; no host clock is used.
 */
`include "clhi_params.svh"

module clhi_tick
    import clhi_pkg::*;
(
    input  wire logic clk_sys_in,
    input  wire logic rstn_in,
    output logic      tick_out
);

    clhi_tick_type s_r;   // divider state
    clhi_tick_type s_nxt; // next divider state

    // ======================================================
    // divider: pulse once every scan period
    always_comb begin
        s_nxt      = s_r;
        s_nxt.tick = 1'b0;
        if (s_r.div == 8'h00) begin
            s_nxt.div  = 8'(`CLHI_SCAN_DIV - 1);
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.div = s_r.div - 8'h01;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tick_out = s_r.tick;

endmodule : clhi_tick

// [hw/clhi_seg.sv]
/*
 * segment latches: serial 40-bit chain and parallel holding latch.
 * assumes shift and load come from the scanner as one-cycle enables.
 */
`include "clhi_params.svh"

module clhi_seg
    import clhi_pkg::*;
(
    input  wire logic                   clk_sys_in,
    input  wire logic                   rstn_in,
    input  wire logic                   shift_in,
    input  wire logic                   bit_in,
    input  wire logic                   load_in,
    output logic [`CLHI_SEG_W-1:0]      seg_out
);

    clhi_seg_type s_r;   // latch state
    clhi_seg_type s_nxt; // next latch state

    // ======================================================
    // copy first, then shift: load sees the chain before this shift
    always_comb begin
        s_nxt = s_r;
        if (load_in) begin
            s_nxt.hold = s_r.chain;
        end
        if (shift_in) begin
            s_nxt.chain = {s_r.chain[`CLHI_SEG_W-2:0], bit_in};
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign seg_out = s_r.hold;

endmodule : clhi_seg

// [hw/clhi_main.sv]
/*
 * host port and display memory logic of a character display controller:
 * command and data holding registers, address pointer, busy flag,
 * text and user glyph memories, and the panel scanner.
 * assumes host pins are synchronous to clk_sys_in and that a transfer
 * is taken on the falling edge of the enable strobe.
 */
`include "clhi_params.svh"

// What this block does
// - select hi pin enables the parallel port; no serial port
// - bus width bit picks 4 or 8 bits
// - command and data holding registers, 8 bits
// - data read reloads holder from next address
// - data write copies holder into memory
// - command register never reads back
// - select and read/write decode four operations
// - status read: busy on bit 7, pointer below
// - busy refuses new instructions
// - busy readable in parallel modes only
// - text memory holds 80 codes of 8 bits
// - code selects fixed or user glyph
// - one line layout from first position
// - two lines, line two starts at 40h
// - display shift moves window, not contents
// - address instructions load the pointer
// - each data access steps pointer by one
// - 16 or 8 commons, 40 segments
// - serial chain then parallel segment latch
// - cursor, blink and inversion at cursor
// - internal timing generator makes the scan timing
// - direction bit: one up, zero down
// - function set holds width and line bits
// - clear fills 20h, pointer to zero
module clhi_main
    import clhi_pkg::*;
#(
    parameter int CLR_CYC = `CLHI_CLR_CYC   // clear execution cycles
)(
    input  wire logic                   clk_sys_in,
    input  wire logic                   rstn_in,
    input  wire logic                   host_port_select_hi_in,
    input  wire logic                   host_port_select_lo_in,
    input  wire logic                   register_select_line_in,
    input  wire logic                   rw_in,
    input  wire logic                   en_in,
    input  wire logic [7:0]             db_in,
    output logic [7:0]                  db_out,
    output logic                        db_oe_out,
    output logic                        busy_flag_out,
    output logic [`CLHI_SEG_W-1:0]      seg_out,
    output logic [`CLHI_COM_W-1:0]      com_out
);

    // ======================================================
    // declarations
    clhi_main_type s_r;        // all block state
    clhi_main_type s_nxt;      // next block state
    logic          tick;       // scan enable
    logic          parallel;   // parallel port selected
    logic          busy;       // internal operation running
    logic          fall;       // enable strobe falling edge
    logic          done;       // a whole byte moved
    logic [7:0]    byte_w;     // assembled write byte
    logic [7:0]    rd_val;     // byte a read presents
    logic [7:0]    code;       // character under the scanner
    logic [4:0]    pat;        // glyph row dots
    logic          pix;        // dot shifted out
    logic          at_cur;     // scanner sits on the cursor
    logic [6:0]    pos;        // window position of the scanner
    logic          last_dot;   // end of a row

    // ======================================================
    // text memory index of a pointer value; line two sits at 40h
    function automatic logic [6:0] f_idx(input logic [6:0] a);
        if (a >= `CLHI_LINE2_BASE) begin
            f_idx = 7'(a - `CLHI_LINE2_BASE + 7'(`CLHI_LINE_LEN));
        end else begin
            f_idx = a;
        end
    endfunction : f_idx

    // pointer step by one with wrap per memory and layout
    function automatic logic [6:0] f_step(input logic [6:0] a,
                                          input logic up,
                                          input logic two,
                                          input logic cg);
        if (cg) begin
            f_step = {1'b0, up ? 6'(a[5:0] + 6'h01)
                               : 6'(a[5:0] - 6'h01)};
        end else if (!two) begin
            if (up) begin
                f_step = (a == `CLHI_TEXT_LAST) ? 7'h00 : 7'(a + 7'h01);
            end else begin
                f_step = (a == 7'h00) ? `CLHI_TEXT_LAST : 7'(a - 7'h01);
            end
        end else if (up) begin
            // line ends are not adjacent to the next line start
            if (a == `CLHI_LINE1_LAST) begin
                f_step = `CLHI_LINE2_BASE;
            end else if (a == `CLHI_LINE2_LAST) begin
                f_step = 7'h00;
            end else begin
                f_step = 7'(a + 7'h01);
            end
        end else begin
            if (a == 7'h00) begin
                f_step = `CLHI_LINE2_LAST;
            end else if (a == `CLHI_LINE2_BASE) begin
                f_step = `CLHI_LINE1_LAST;
            end else begin
                f_step = 7'(a - 7'h01);
            end
        end
    endfunction : f_step

    // window offset step, modulo the line length of the layout
    function automatic logic [6:0] f_shift(input logic [6:0] s,
                                           input logic right,
                                           input logic two);
        logic [6:0] len;
        len = two ? 7'(`CLHI_LINE_LEN) : 7'(`CLHI_TEXT_DEPTH);
        if (right) begin
            f_shift = (s == 7'h00) ? 7'(len - 7'h01) : 7'(s - 7'h01);
        end else begin
            f_shift = (s == 7'(len - 7'h01)) ? 7'h00 : 7'(s + 7'h01);
        end
    endfunction : f_shift

    // fixed glyph stand-in: real artwork is a mask table not kept here
    function automatic logic [4:0] f_rom(input logic [7:0] c,
                                         input logic [2:0] r);
        f_rom = (r == 3'h7) ? 5'h00 : 5'(c[4:0] ^ {2'h0, r});
    endfunction : f_rom

    // ======================================================
    // shared decode
    assign parallel = host_port_select_hi_in;
    assign busy     = (s_r.st != ST_IDLE);
    assign fall     = s_r.en_d & ~en_in & parallel;
    // in 4-bit mode only the second nibble completes a byte
    assign done     = fall & (s_r.dl | s_r.nib);
    assign byte_w   = s_r.dl ? db_in : {s_r.hi_nib, db_in[7:4]};

    // ======================================================
    // read value: status or holder, never the command code
    always_comb begin
        if (register_select_line_in) begin
            rd_val = s_r.dr;
        end else begin
            // busy only reported on a parallel port
            rd_val = {busy & parallel, s_r.ptr};
        end
    end

    // ======================================================
    // scanner: which character and dot is being shifted out
    always_comb begin
        pos = 7'(({4'h0, s_r.chr} + s_r.shift)
                 % (s_r.nl ? 7'(`CLHI_LINE_LEN) : 7'(`CLHI_TEXT_DEPTH)));
        if (s_r.nl && s_r.row[3]) begin
            pos = 7'(pos + 7'(`CLHI_LINE_LEN));
        end
        code = s_r.text[pos];
        // user glyphs answer codes 00h to 0Fh, bit 3 ignored
        if (code[7:4] == 4'h0) begin
            pat = s_r.glyph[{code[2:0], s_r.row[2:0]}][4:0];
        end else begin
            pat = f_rom(code, s_r.row[2:0]);
        end
        at_cur = !s_r.sel_cg && (pos == f_idx(s_r.ptr));
        pix    = pat[3'h4 - s_r.dot];
        if (at_cur && s_r.cur && s_r.row[2:0] == 3'h7) begin
            pix = 1'b1;
        end
        if (at_cur && s_r.blk && s_r.frame[5]) begin
            pix = ~pix;
        end
        if (!s_r.disp) begin
            pix = 1'b0;
        end
        last_dot = (s_r.dot == 3'h4) && (s_r.chr == 3'h7);
    end

    // ======================================================
    // next state
    always_comb begin
        s_nxt      = s_r;
        s_nxt.en_d = en_in;
        // read drive: pins sampled synchronously, one cycle late
        s_nxt.oe   = en_in & rw_in & parallel;
        s_nxt.dout = s_r.dl ? rd_val
                   : (s_r.nib ? {rd_val[3:0], 4'h0}
                              : {rd_val[7:4], 4'h0});

        // nibble pairing, for reads and writes alike
        if (fall && !s_r.dl) begin
            s_nxt.nib = ~s_r.nib;
            if (!s_r.nib) begin
                s_nxt.hi_nib = db_in[7:4];
            end
        end

        // execution timer, busy clears when it runs out
        case (s_r.st)
            ST_IDLE: begin
                s_nxt.st = ST_IDLE;
            end
            ST_EXEC: begin
                if (s_r.cnt <= 16'h0001) begin
                    s_nxt.st = ST_IDLE;
                    if (s_r.reload) begin
                        s_nxt.reload = 1'b0;
                        s_nxt.dr = s_r.sel_cg ? s_r.glyph[s_r.ptr[5:0]]
                                 : s_r.text[f_idx(s_r.ptr)];
                    end
                end else begin
                    s_nxt.cnt = s_r.cnt - 16'h0001;
                end
            end
            ST_CLR: begin
                // fill one cell per cycle, well inside the clear time
                if (s_r.clr_idx < 7'(`CLHI_TEXT_DEPTH)) begin
                    s_nxt.text[s_r.clr_idx] = `CLHI_BLANK;
                    s_nxt.clr_idx = s_r.clr_idx + 7'h01;
                end
                if (s_r.cnt <= 16'h0001) begin
                    s_nxt.st = ST_IDLE;
                end else begin
                    s_nxt.cnt = s_r.cnt - 16'h0001;
                end
            end
            default: begin
                s_nxt.st = ST_IDLE;
            end
        endcase

        // host transfers; anything but a status read is dropped while busy
        if (done && !busy && !rw_in) begin
            s_nxt.st  = ST_EXEC;
            s_nxt.cnt = 16'(`CLHI_OP_CYC);
            if (!register_select_line_in) begin
                // instruction: the leading one picks the command
                s_nxt.cmd = byte_w;
                if (byte_w[`CLHI_CMD_TEXTA]) begin
                    s_nxt.ptr    = byte_w[6:0];
                    s_nxt.sel_cg = 1'b0;
                    s_nxt.reload = 1'b1;
                end else if (byte_w[`CLHI_CMD_GLYPHA]) begin
                    s_nxt.ptr    = {1'b0, byte_w[5:0]};
                    s_nxt.sel_cg = 1'b1;
                    s_nxt.reload = 1'b1;
                end else if (byte_w[`CLHI_CMD_FUNC]) begin
                    s_nxt.dl   = byte_w[`CLHI_F_DL];
                    s_nxt.nl   = byte_w[`CLHI_F_N];
                    s_nxt.font = byte_w[`CLHI_F_FONT];
                    s_nxt.nib  = 1'b0;
                    s_nxt.shift = 7'h00;
                end else if (byte_w[`CLHI_CMD_SHIFT]) begin
                    if (byte_w[`CLHI_F_SC]) begin
                        s_nxt.shift = f_shift(s_r.shift, byte_w[`CLHI_F_RL],
                                              s_r.nl);
                    end else begin
                        s_nxt.ptr = f_step(s_r.ptr, byte_w[`CLHI_F_RL],
                                           s_r.nl, s_r.sel_cg);
                    end
                end else if (byte_w[`CLHI_CMD_DISP]) begin
                    s_nxt.disp = byte_w[`CLHI_F_D];
                    s_nxt.cur  = byte_w[`CLHI_F_C];
                    s_nxt.blk  = byte_w[`CLHI_F_B];
                end else if (byte_w[`CLHI_CMD_ENTRY]) begin
                    s_nxt.id    = byte_w[`CLHI_F_ID];
                    s_nxt.sh_en = byte_w[`CLHI_F_SH];
                end else if (byte_w[`CLHI_CMD_HOME]) begin
                    s_nxt.ptr    = 7'h00;
                    s_nxt.sel_cg = 1'b0;
                    s_nxt.shift  = 7'h00;
                    s_nxt.cnt    = 16'(CLR_CYC);
                end else if (byte_w[`CLHI_CMD_CLR]) begin
                    s_nxt.st      = ST_CLR;
                    s_nxt.cnt     = 16'(CLR_CYC);
                    s_nxt.clr_idx = 7'h00;
                    s_nxt.ptr     = 7'h00;
                    s_nxt.sel_cg  = 1'b0;
                    s_nxt.shift   = 7'h00;
                    s_nxt.id      = 1'b1;
                end
            end else begin
                // data write lands at the pointer, then steps it
                s_nxt.dr = byte_w;
                if (s_r.sel_cg) begin
                    s_nxt.glyph[s_r.ptr[5:0]] = byte_w;
                end else begin
                    s_nxt.text[f_idx(s_r.ptr)] = byte_w;
                    if (s_r.sh_en) begin
                        s_nxt.shift = f_shift(s_r.shift, ~s_r.id, s_r.nl);
                    end
                end
                s_nxt.ptr = f_step(s_r.ptr, s_r.id, s_r.nl,
                                   s_r.sel_cg);
            end
        end else if (done && !busy && register_select_line_in) begin
            // data read: step, then refill the holder at the end
            s_nxt.st     = ST_EXEC;
            s_nxt.cnt    = 16'(`CLHI_OP_CYC);
            s_nxt.reload = 1'b1;
            s_nxt.ptr    = f_step(s_r.ptr, s_r.id, s_r.nl,
                                  s_r.sel_cg);
        end

        // panel scan: 40 dots per row, 8 or 16 rows per frame
        if (tick) begin
            if (s_r.dot == 3'h4) begin
                s_nxt.dot = 3'h0;
                s_nxt.chr = s_r.chr + 3'h1;
            end else begin
                s_nxt.dot = s_r.dot + 3'h1;
            end
            if (last_dot) begin
                s_nxt.com = '0;
                s_nxt.com[s_r.row] = 1'b1;
                if (s_r.row == (s_r.nl ? 4'hF : 4'h7)) begin
                    s_nxt.row   = 4'h0;
                    s_nxt.frame = s_r.frame + 6'h01;
                end else begin
                    s_nxt.row = s_r.row + 4'h1;
                end
            end
        end
    end

    // ======================================================
    // state register; text memory starts blank
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s_r       <= '0;
            s_r.st    <= ST_IDLE;
            s_r.id    <= 1'b1;
            s_r.dl    <= 1'b1;
            s_r.text  <= {`CLHI_TEXT_DEPTH{`CLHI_BLANK}};
            s_r.en_d  <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ======================================================
    // timing generator and segment latches
    clhi_tick u_tick (
        .clk_sys_in (clk_sys_in),
        .rstn_in    (rstn_in),
        .tick_out   (tick)
    );

    // the row's first dot shifts while the previous row is copied out
    clhi_seg u_seg (
        .clk_sys_in (clk_sys_in),
        .rstn_in    (rstn_in),
        .shift_in   (tick),
        .bit_in     (pix),
        .load_in    (tick & s_r.dot == 3'h0 & s_r.chr == 3'h0),
        .seg_out    (seg_out)
    );

    assign db_out        = s_r.dout;
    assign db_oe_out     = s_r.oe;
    assign busy_flag_out = busy;
    assign com_out       = s_r.com;

endmodule : clhi_main

// [dv/clhi_checker.sv]
/* checker of the host port, bound to clhi_main.
   assumes one clock and the 463-cycle op time. */
`include "clhi_params.svh"
module clhi_checker
    import clhi_pkg::*;
#(
    parameter int CLR_CYC = 100   // clear execution cycles
)(
    input wire logic       clk_sys_in,
    input wire logic       rstn_in,
    input wire logic       host_port_select_hi_in,
    input wire logic       register_select_line_in,
    input wire logic       rw_in,
    input wire logic       en_in,
    input wire logic [7:0] db_out,
    input wire logic       db_oe_out,
    input wire logic       busy_flag_out,
    input wire logic [`CLHI_COM_W-1:0] com_out
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int OP = `CLHI_OP_CYC;
    logic [15:0] run_r;   // length of the current busy run
    // ==========================================
    // helper: counts busy cycles, so its length is checked exactly
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) run_r <= '0;
        else if (!busy_flag_out) run_r <= '0;
        else run_r <= run_r + 16'h1;
    end
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);
    // strobe fall that must be taken: write or data read, idle
    sequence s_taken;
        host_port_select_hi_in && en_in ##1 !en_in && !busy_flag_out
            && (!rw_in || register_select_line_in);
    endsequence
    busy_set_a: assert property (s_taken |=> busy_flag_out)
        else $error("busy not raised after transfer");
    busy_len_a: assert property ($fell(busy_flag_out) |->
        run_r == OP || run_r == CLR_CYC) else $error("busy length wrong");
    busy_quiet_a: assert property (!busy_flag_out && !$fell(en_in)
        |=> !busy_flag_out) else $error("busy without cause");
    oe_on_a: assert property (
        (host_port_select_hi_in && en_in && rw_in)[*2] |-> db_oe_out)
        else $error("read data not driven");
    oe_off_a: assert property (!en_in |=> !db_oe_out)
        else $error("lines driven without strobe");
    oe_wr_a: assert property (!rw_in |=> !db_oe_out)
        else $error("lines driven on write");
    status_bit_a: assert property (
        (en_in && rw_in && !register_select_line_in
        && host_port_select_hi_in)[*2] |-> db_out[7] == $past(busy_flag_out))
        else $error("status bit 7 not busy");
    com_hot_a: assert property ($onehot0(com_out))
        else $error("common rows not one-hot");
endmodule : clhi_checker
bind clhi_main clhi_checker #(.CLR_CYC(CLR_CYC)) u_chk(.clk_sys_in,
    .rstn_in, .host_port_select_hi_in, .register_select_line_in, .rw_in,
    .en_in, .db_out, .db_oe_out, .busy_flag_out, .com_out);

// [dv/clhi_host_model.sv]
/* host model: drives the parallel port through tasks.
   assumes 8-bit width and a 40 ns clock. */
module clhi_host_model(
    input  wire logic       clk_in,
    input  wire logic [7:0] d_in,
    output logic            rs_out,
    output logic            rw_out,
    output logic            en_out,
    output logic [7:0]      d_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {rs_out, rw_out, en_out, d_out} = '0;
    // ==========================================
    // one strobe; inputs held until the fall is sampled
    task automatic xfer(input logic rs, input logic rw, input logic [7:0] d,
                        output logic [7:0] q);
        @(negedge clk_in);
        {rs_out, rw_out, d_out, en_out} = {rs, rw, d, 1'b1};
        repeat (2) @(negedge clk_in);
        q = d_in;
        en_out = 1'b0;
        @(negedge clk_in);
        d_out = ~d;   // released lines must not keep the last value
    endtask : xfer
    // polls status before the next request, bounded
    task automatic wait_idle(output logic [7:0] st);
        for (int i = 0; i < 400; i++) begin
            xfer(1'b0, 1'b1, 8'h00, st);
            if (st[7] === 1'b0) return;
        end
    endtask : wait_idle
endmodule : clhi_host_model

// [dv/tb_top.sv]
/* testbench of clhi_main: host calls with expected values.
   assumes a short clear time of 100 cycles. */
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import clhi_pkg::*;
    logic        clk_sys_in = 1'b0;
    logic        rstn_in = 1'b0;
    logic        sel = 1'b1;   // parallel strap, dropped once for serial
    logic        rs, rw, en, oe, busy;
    logic [7:0]  db_w, db_r, q;
    logic [39:0] seg;          // segment holding latch
    logic [15:0] com;          // common rows
    int         bad_count = 0;
    int         n_checks = 0;
    always #20 clk_sys_in = ~clk_sys_in;
    clhi_main #(.CLR_CYC(100)) u_dut(.clk_sys_in, .rstn_in,
        .host_port_select_hi_in(sel), .host_port_select_lo_in(1'b0),
        .register_select_line_in(rs), .rw_in(rw), .en_in(en),
        .db_in(db_w), .db_out(db_r), .db_oe_out(oe),
        .busy_flag_out(busy), .seg_out(seg), .com_out(com));
    clhi_host_model u_host(.clk_in(clk_sys_in), .d_in(db_r), .rs_out(rs),
        .rw_out(rw), .en_out(en), .d_out(db_w));
    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : final_report
    // write one byte, then poll until idle; q holds final status
    task automatic op(input logic r, input logic [7:0] d);
        u_host.xfer(r, 1'b0, d, q);
        poll();
    endtask : op
    // bounded poll; a busy flag that never drops ends the run as a fail
    task automatic poll();
        u_host.wait_idle(q);
        if (q[7] !== 1'b0) begin
            bad_count++;
            final_report();
        end
    endtask : poll
    // ==========================================
    // main sequence
    initial begin
        repeat (5) @(negedge clk_sys_in);
        rstn_in = 1'b1;
        poll();
        chk(q, 8'h00);
        op(1'b0, 8'h85);
        chk(q, 8'h05);
        u_host.xfer(1'b1, 1'b0, 8'h41, q);
        u_host.xfer(1'b0, 1'b1, 8'h00, q);
        chk(q, 8'h86);
        op(1'b0, 8'h90);   // sent while busy, must be dropped
        chk(q, 8'h06);
        op(1'b0, 8'h85);
        u_host.xfer(1'b1, 1'b1, 8'h00, q);
        chk(q, 8'h41);
        poll();
        chk(q, 8'h06);
        op(1'b0, 8'h04);   // direction down
        op(1'b1, 8'h42);
        chk(q, 8'h05);
        op(1'b0, 8'h01);
        chk(q, 8'h00);
        op(1'b0, 8'h83);
        u_host.xfer(1'b1, 1'b1, 8'h00, q);
        chk(q, 8'h20);
        poll();
        sel = 1'b0;        // serial strap: parallel pins ignored
        u_host.xfer(1'b0, 1'b0, 8'h8A, q);
        sel = 1'b1;
        poll();
        chk(q, 8'h04);
        op(1'b0, 8'h0E);   // display and cursor on, cursor at 04h
        @(posedge com[6]); // row 7 then scans wholly with display on
        @(posedge com[7]);
        repeat (30) @(negedge clk_sys_in);
        chk(seg, 40'h00_000F_8000);
        final_report();
    end
    // watchdog well beyond the roughly 8000 cycles the tests need
    initial begin
        #(40 * 40000);
        bad_count++;
        final_report();
    end
endmodule : tb_top
